/* File: design/configurable_io_port_bank.sv */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none

module configurable_io_port_bank (
    input  wire logic       mclk_i,          // Core clock, 50 MHz
    input  wire logic       reset_i,         // Synchronous reset, active high
    input  wire logic       ce_i,            // Clock enable, freezes state when low
    input  wire logic [3:0] reg_addr_i,      // Register address
    input  wire logic [7:0] reg_wdata_i,     // Register write data
    input  wire logic       reg_wr_i,        // Write strobe
    input  wire logic       reg_rd_i,        // Read strobe
    output logic      [7:0] reg_rdata_o,     // Read data, cycle after strobe
    input  wire logic [7:0] port0_pins_i,    // Port 0 pin levels
    input  wire logic [7:0] port1_pins_i,    // Port 1 pin levels
    input  wire logic [1:0] port3_pins_i,    // Port 3 pin levels
    output logic      [7:0] port0_out_o,     // Port 0 strong drive value
    output logic      [7:0] port0_oe_o,      // Port 0 strong drive enable
    output logic      [7:0] port0_pullup_o,  // Port 0 weak pull-up enable
    output logic      [7:0] port1_out_o,     // Port 1 strong drive value
    output logic      [7:0] port1_oe_o,      // Port 1 strong drive enable
    output logic      [7:0] port1_pullup_o,  // Port 1 weak pull-up enable
    output logic      [1:0] port3_out_o,     // Port 3 strong drive value
    output logic      [1:0] port3_oe_o,      // Port 3 strong drive enable
    output logic      [1:0] port3_pullup_o,  // Port 3 weak pull-up enable
    output logic            ext_reset_o      // External reset request, active high
);

    logic [17:0] latch_q;
    logic [17:0] mode_a_q;
    logic [17:0] mode_b_q;
    logic [7:0]  analog_dis_q;
    logic [7:0]  user_cfg_q;
    logic [17:0] sync1_q;
    logic [17:0] sync2_q;
    logic [17:0] pin_read_q;
    logic [17:0] out_q;
    logic [17:0] oe_q;
    logic [17:0] pu_q;
    logic [17:0] out_d;
    logic [17:0] oe_d;
    logic [17:0] pu_d;
    logic [17:0] consumed;
    logic [17:0] dig_dis;
    logic [17:0] pins_all;
    logic [7:0]  rdata_d;
    logic [7:0]  rdata_q;
    logic        ext_reset_q;
    logic        reset_pin_function_enable;
    logic [1:0]  clk_src;
    logic [4:0]  clk_pins;
    logic [4:0]  pin_count;
    logic        wr_en;

    assign pins_all = {port3_pins_i, port1_pins_i, port0_pins_i};
    assign wr_en    = ce_i & reg_wr_i;
    assign reset_pin_function_enable      = user_cfg_q[gpio_bank_pkg::CFG_RPE_BIT];
    assign clk_src  = user_cfg_q[gpio_bank_pkg::CFG_CLK_LSB +: 2];

    // Pins taken by the clock source or the reset function
    always_comb begin
        consumed = '0;
        clk_pins = 5'h0;
        case (clk_src)
            gpio_bank_pkg::CLK_EXT_IN: begin
                consumed[gpio_bank_pkg::XTAL_IN_IDX] = 1'b1;
                clk_pins = 5'h1;
            end
            gpio_bank_pkg::CLK_CRYSTAL: begin
                consumed[gpio_bank_pkg::XTAL_IN_IDX]  = 1'b1;
                consumed[gpio_bank_pkg::XTAL_OUT_IDX] = 1'b1;
                clk_pins = 5'h2;
            end
            default: begin
                clk_pins = 5'h0;
            end
        endcase
        consumed[gpio_bank_pkg::RESET_PIN_IDX] = reset_pin_function_enable;
    end

    // Status tells software how many pins are left for general use
    assign pin_count = gpio_bank_pkg::MAX_IO_PINS - clk_pins - {4'h0, reset_pin_function_enable};

    // Only port 0 carries analog inputs, so the other ports never cut their inputs
    assign dig_dis = {10'h000, analog_dis_q};

    // Output latches
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            latch_q <= gpio_bank_pkg::LATCH_RST;
        end else if (wr_en) begin
            case (reg_addr_i)
                gpio_bank_pkg::P0_LATCH_ADDR: begin
                    latch_q[7:0] <= reg_wdata_i;
                end
                gpio_bank_pkg::P1_LATCH_ADDR: begin
                    latch_q[15:8] <= reg_wdata_i;
                end
                gpio_bank_pkg::P3_LATCH_ADDR: begin
                    latch_q[17:16] <= reg_wdata_i[1:0];
                end
                default: begin
                    latch_q <= latch_q;
                end
            endcase
        end
    end

    // Mode registers; reset leaves every pin input-only
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mode_a_q <= gpio_bank_pkg::MODE_A_RST;
            mode_b_q <= gpio_bank_pkg::MODE_B_RST;
        end else if (wr_en) begin
            case (reg_addr_i)
                gpio_bank_pkg::P0_MODE_A_ADDR: begin
                    mode_a_q[7:0] <= reg_wdata_i;
                end
                gpio_bank_pkg::P0_MODE_B_ADDR: begin
                    mode_b_q[7:0] <= reg_wdata_i;
                end
                gpio_bank_pkg::P1_MODE_A_ADDR: begin
                    mode_a_q[15:8] <= reg_wdata_i | gpio_bank_pkg::P1_FIXED_BIT;
                end
                gpio_bank_pkg::P1_MODE_B_ADDR: begin
                    mode_b_q[15:8] <= reg_wdata_i & ~gpio_bank_pkg::P1_FIXED_BIT;
                end
                gpio_bank_pkg::P3_MODE_A_ADDR: begin
                    mode_a_q[17:16] <= reg_wdata_i[1:0];
                end
                gpio_bank_pkg::P3_MODE_B_ADDR: begin
                    mode_b_q[17:16] <= reg_wdata_i[1:0];
                end
                default: begin
                    mode_a_q <= mode_a_q;
                end
            endcase
        end
    end

    // Analog input disable and user configuration
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            analog_dis_q <= gpio_bank_pkg::ANALOG_RST;
        end else if (wr_en && reg_addr_i == gpio_bank_pkg::ANALOG_DIS_ADDR) begin
            analog_dis_q <= reg_wdata_i & gpio_bank_pkg::ANALOG_MASK;
        end
    end

    // Stands in for the non-volatile configuration byte
    // Writable at run time so every clock and reset option can be reached
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            user_cfg_q <= gpio_bank_pkg::USER_CFG_RST;
        end else if (wr_en && reg_addr_i == gpio_bank_pkg::USER_CFG_ADDR) begin
            user_cfg_q <= reg_wdata_i & 8'h07;
        end
    end

    // Per-pin driver decode
    // Taken pins are forced input-only while their stored mode bits stay as written, except pin 13's, which are always stored as input-only
    genvar i;
    generate
        for (i = 0; i < gpio_bank_pkg::NUM_PINS; i++) begin : g_pin
            gpio_bank_pkg::drive_mode_type mode;
            always_comb begin
                mode = gpio_bank_pkg::drive_mode_type'({mode_a_q[i], mode_b_q[i]});
                if (i == gpio_bank_pkg::RESET_PIN_IDX || consumed[i]) begin
                    mode = gpio_bank_pkg::INPUT_ONLY;
                end else if (i == gpio_bank_pkg::SCL_PIN_IDX ||
                             i == gpio_bank_pkg::SDA_PIN_IDX) begin
                    if (mode != gpio_bank_pkg::INPUT_ONLY) begin
                        mode = gpio_bank_pkg::OPEN_DRAIN;
                    end
                end
                out_d[i] = 1'b0;
                oe_d[i]  = 1'b0;
                pu_d[i]  = 1'b0;
                case (mode)
                    gpio_bank_pkg::QUASI_BIDIR: begin
                        oe_d[i] = ~latch_q[i];
                        pu_d[i] = latch_q[i];
                    end
                    gpio_bank_pkg::PUSH_PULL: begin
                        out_d[i] = latch_q[i];
                        oe_d[i]  = 1'b1;
                    end
                    gpio_bank_pkg::OPEN_DRAIN: begin
                        oe_d[i] = ~latch_q[i];
                    end
                    gpio_bank_pkg::INPUT_ONLY: begin
                        oe_d[i] = 1'b0;
                    end
                    default: begin
                        oe_d[i] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // Driver flops; every pin floats from reset onward
    // Registered so that a mode write never glitches a pin through the decode
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            out_q <= '0;
            oe_q  <= '0;
            pu_q  <= '0;
        end else if (ce_i) begin
            out_q <= out_d;
            oe_q  <= oe_d;
            pu_q  <= pu_d;
        end
    end

    // Pin synchronisers and software-visible pin levels
    // Two stages guard against metastability; software sees a pin three cycles late
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            pin_read_q <= '0;
        end else if (ce_i) begin
            sync1_q    <= pins_all;
            sync2_q    <= sync1_q;
            pin_read_q <= sync2_q & ~dig_dis;
        end
    end

    // Pin level low while enabled is a reset request
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ext_reset_q <= 1'b0;
        end else if (ce_i) begin
            ext_reset_q <= reset_pin_function_enable & ~sync2_q[gpio_bank_pkg::RESET_PIN_IDX];
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        case (reg_addr_i)
            gpio_bank_pkg::P0_LATCH_ADDR:   rdata_d = latch_q[7:0];
            gpio_bank_pkg::P0_MODE_A_ADDR:  rdata_d = mode_a_q[7:0];
            gpio_bank_pkg::P0_MODE_B_ADDR:  rdata_d = mode_b_q[7:0];
            gpio_bank_pkg::P0_PINS_ADDR:    rdata_d = pin_read_q[7:0];
            gpio_bank_pkg::P1_LATCH_ADDR:   rdata_d = latch_q[15:8];
            gpio_bank_pkg::P1_MODE_A_ADDR:  rdata_d = mode_a_q[15:8];
            gpio_bank_pkg::P1_MODE_B_ADDR:  rdata_d = mode_b_q[15:8];
            gpio_bank_pkg::P1_PINS_ADDR:    rdata_d = pin_read_q[15:8];
            gpio_bank_pkg::P3_LATCH_ADDR:   rdata_d = {6'h00, latch_q[17:16]};
            gpio_bank_pkg::P3_MODE_A_ADDR:  rdata_d = {6'h00, mode_a_q[17:16]};
            gpio_bank_pkg::P3_MODE_B_ADDR:  rdata_d = {6'h00, mode_b_q[17:16]};
            gpio_bank_pkg::P3_PINS_ADDR:    rdata_d = {6'h00, pin_read_q[17:16]};
            gpio_bank_pkg::ANALOG_DIS_ADDR: rdata_d = analog_dis_q;
            gpio_bank_pkg::USER_CFG_ADDR:   rdata_d = user_cfg_q;
            gpio_bank_pkg::STATUS_ADDR:     rdata_d = {3'h0, pin_count};
            default:                        rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            rdata_q <= reg_rd_i ? rdata_d : 8'h00;
        end
    end

    assign reg_rdata_o    = rdata_q;
    assign port0_out_o    = out_q[7:0];
    assign port0_oe_o     = oe_q[7:0];
    assign port0_pullup_o = pu_q[7:0];
    assign port1_out_o    = out_q[15:8];
    assign port1_oe_o     = oe_q[15:8];
    assign port1_pullup_o = pu_q[15:8];
    assign port3_out_o    = out_q[17:16];
    assign port3_oe_o     = oe_q[17:16];
    assign port3_pullup_o = pu_q[17:16];
    assign ext_reset_o    = ext_reset_q;

endmodule

`default_nettype wire

/* File: design/gpio_bank_pkg.sv */
package gpio_bank_pkg;

    localparam int NUM_PINS = 18;
    localparam int ADDR_W   = 4;

    // Register offsets on the plain register port
    localparam logic [3:0] P0_LATCH_ADDR  = 4'h0;
    localparam logic [3:0] P0_MODE_A_ADDR = 4'h1;
    localparam logic [3:0] P0_MODE_B_ADDR = 4'h2;
    localparam logic [3:0] P0_PINS_ADDR   = 4'h3;
    localparam logic [3:0] P1_LATCH_ADDR  = 4'h4;
    localparam logic [3:0] P1_MODE_A_ADDR = 4'h5;
    localparam logic [3:0] P1_MODE_B_ADDR = 4'h6;
    localparam logic [3:0] P1_PINS_ADDR   = 4'h7;
    localparam logic [3:0] P3_LATCH_ADDR  = 4'h8;
    localparam logic [3:0] P3_MODE_A_ADDR = 4'h9;
    localparam logic [3:0] P3_MODE_B_ADDR = 4'ha;
    localparam logic [3:0] P3_PINS_ADDR   = 4'hb;
    localparam logic [3:0] ANALOG_DIS_ADDR = 4'hc;
    localparam logic [3:0] USER_CFG_ADDR  = 4'hd;
    localparam logic [3:0] STATUS_ADDR    = 4'he;

    // Driver type code formed from {mode_a, mode_b}
    typedef enum logic [1:0] {
        QUASI_BIDIR = 2'b00,
        PUSH_PULL   = 2'b01,
        INPUT_ONLY  = 2'b10,
        OPEN_DRAIN  = 2'b11
    } drive_mode_type;

    // Flat pin indices: port 0 is 7:0, port 1 is 15:8, port 3 is 17:16
    localparam int RESET_PIN_IDX = 13;
    localparam int SCL_PIN_IDX   = 10;
    localparam int SDA_PIN_IDX   = 11;
    localparam int XTAL_OUT_IDX  = 16;
    localparam int XTAL_IN_IDX   = 17;

    // Values after reset, the analog disable write mask and the fixed port 1 mode bit
    localparam logic [17:0] LATCH_RST   = 18'h3ffff;
    localparam logic [17:0] MODE_A_RST  = 18'h3ffff;
    localparam logic [17:0] MODE_B_RST  = 18'h00000;
    localparam logic [7:0]  ANALOG_RST  = 8'h00;
    localparam logic [7:0]  ANALOG_MASK = 8'h3e;
    localparam logic [7:0]  USER_CFG_RST = 8'h00;
    localparam logic [7:0]  P1_FIXED_BIT = 8'h20;

    // User configuration byte fields
    localparam int CFG_CLK_LSB = 0;
    localparam int CFG_RPE_BIT = 2;

    // Clock source codes
    localparam logic [1:0] CLK_RC_OSC   = 2'h0;
    localparam logic [1:0] CLK_WDT_OSC  = 2'h1;
    localparam logic [1:0] CLK_EXT_IN   = 2'h2;
    localparam logic [1:0] CLK_CRYSTAL  = 2'h3;

    localparam logic [4:0] MAX_IO_PINS = 5'h12;

endpackage

/* File: verif/io_bank_props.sv */
`timescale 1ns/10ps
`default_nettype none

module io_bank_props (
    input wire logic       mclk_i,         // Core clock
    input wire logic       reset_i,        // Sync reset
    input wire logic       ce_i,           // Clock enable
    input wire logic [3:0] reg_addr_i,     // Address
    input wire logic       reg_rd_i,       // Read strobe
    input wire logic [7:0] reg_rdata_o,    // Read data
    input wire logic [7:0] port1_pins_i,   // Port 1 levels
    input wire logic [7:0] port0_oe_o,     // Port 0 enables
    input wire logic [7:0] port0_pullup_o, // Port 0 pull-ups
    input wire logic [7:0] port1_out_o,    // Port 1 values
    input wire logic [7:0] port1_oe_o,     // Port 1 enables
    input wire logic [7:0] port1_pullup_o, // Port 1 pull-ups
    input wire logic [1:0] port3_oe_o,     // Port 3 enables
    input wire logic [1:0] port3_pullup_o, // Port 3 pull-ups
    input wire logic       ext_reset_o     // Reset request
);
    logic [17:0] oe_all;
    logic [17:0] pu_all;
    assign oe_all = {port3_oe_o, port1_oe_o, port0_oe_o};
    assign pu_all = {port3_pullup_o, port1_pullup_o, port0_pullup_o};

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_rst_pin_input:
        assert property (port1_oe_o[5] == 1'b0 && port1_pullup_o[5] == 1'b0)
        else $error("reset-shared pin is driven");
    a_serial_no_pullup:
        assert property (port1_pullup_o[3:2] == 2'b00) else $error("serial pin pulled up");
    a_serial_no_high:
        assert property ((port1_oe_o[3:2] & port1_out_o[3:2]) == 2'b00)
        else $error("serial pin driven high");
    a_pullup_not_driving:
        assert property ((pu_all & oe_all) == 18'h00000) else $error("pull-up beside strong drive");
    a_reset_quiet:
        assert property (disable iff (1'b0) reset_i |=> (oe_all == 18'h00000 &&
            pu_all == 18'h00000 && reg_rdata_o == 8'h00 && !ext_reset_o))
        else $error("outputs active after reset");
    a_rdata_idle:
        assert property ((ce_i && !reg_rd_i) |=> reg_rdata_o == 8'h00)
        else $error("read data without read");
    a_analog_mask:
        assert property ((ce_i && reg_rd_i && reg_addr_i == gpio_bank_pkg::ANALOG_DIS_ADDR)
            |=> (reg_rdata_o & ~gpio_bank_pkg::ANALOG_MASK) == 8'h00)
        else $error("analog disable bit outside one to five");
    a_port3_width:
        assert property ((ce_i && reg_rd_i && reg_addr_i[3:2] == 2'b10)
            |=> reg_rdata_o[7:2] == 6'h00) else $error("port 3 upper bits set");
    a_unmapped_zero:
        assert property ((ce_i && reg_rd_i && reg_addr_i == 4'hf) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ext_reset_cause:
        assert property ((ext_reset_o && $past(ce_i) && $past(ce_i, 2) && $past(ce_i, 3))
            |-> !$past(port1_pins_i[5], 3)) else $error("reset request without low pin");

    c_ext_reset: cover property (ext_reset_o);
    c_push_high: cover property (port1_oe_o[0] && port1_out_o[0]);
    c_quasi_weak: cover property (port0_pullup_o != 8'h00);
endmodule

bind configurable_io_port_bank io_bank_props i_io_bank_props (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port1_pins_i(port1_pins_i),
    .port0_oe_o(port0_oe_o), .port0_pullup_o(port0_pullup_o), .port1_out_o(port1_out_o),
    .port1_oe_o(port1_oe_o), .port1_pullup_o(port1_pullup_o), .port3_oe_o(port3_oe_o),
    .port3_pullup_o(port3_pullup_o), .ext_reset_o(ext_reset_o)
);

`default_nettype wire

/* File: verif/board_model.sv */
`timescale 1ns/10ps
`default_nettype none

module board_model (
    input  wire logic [17:0] out_i,     // Strong drive value
    input  wire logic [17:0] oe_i,      // Strong drive enable
    input  wire logic [17:0] pullup_i,  // Weak pull-up enable
    input  wire logic [17:0] ext_low_i, // Board device pulling low
    output logic      [17:0] pin_o      // Resolved pin levels
);
    // Every pin has a board resistor to the supply, so a floating pin reads one
    always_comb begin
        for (int i = 0; i < 18; i++) begin
            if (ext_low_i[i]) begin
                pin_o[i] = 1'b0;
            end else if (oe_i[i]) begin
                pin_o[i] = out_i[i];
            end else begin
                pin_o[i] = 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verif/configurable_io_port_bank_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module configurable_io_port_bank_tb;
    localparam logic [23:0] LAT = 24'h025a0f;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        ext_reset_o;
    logic [17:0] ext_low = 18'h00000;
    logic [1:0]  code;
    logic [1:0]  c;
    wire  [17:0] pins;
    wire  [17:0] outs;
    wire  [17:0] oes;
    wire  [17:0] pus;
    int          n_mismatch = 0;
    int          num_checks = 0;

    configurable_io_port_bank i_configurable_io_port_bank (
        .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .port0_pins_i(pins[7:0]), .port1_pins_i(pins[15:8]),
        .port3_pins_i(pins[17:16]), .port0_out_o(outs[7:0]), .port0_oe_o(oes[7:0]),
        .port0_pullup_o(pus[7:0]), .port1_out_o(outs[15:8]), .port1_oe_o(oes[15:8]),
        .port1_pullup_o(pus[15:8]), .port3_out_o(outs[17:16]), .port3_oe_o(oes[17:16]),
        .port3_pullup_o(pus[17:16]), .ext_reset_o(ext_reset_o)
    );
    board_model i_board_model (
        .out_i(outs), .oe_i(oes), .pullup_i(pus), .ext_low_i(ext_low), .pin_o(pins)
    );

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    function automatic logic [2:0] pin_exp(input logic [1:0] m, input logic l);
        case (m)
            gpio_bank_pkg::QUASI_BIDIR: pin_exp = {~l, 1'b0, l};
            gpio_bank_pkg::PUSH_PULL:   pin_exp = {1'b1, l, 1'b0};
            gpio_bank_pkg::OPEN_DRAIN:  pin_exp = {~l, 1'b0, 1'b0};
            default:                    pin_exp = 3'b000;
        endcase
    endfunction

    task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(negedge mclk_i);
        cmp(18'(reg_rdata_o), 18'(exp));
    endtask

    task automatic do_reset;
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
    endtask

    task automatic chk_reset;
        @(negedge mclk_i);
        cmp(oes | pus, 18'h00000);
        rd(gpio_bank_pkg::P0_LATCH_ADDR, 8'hff);
        rd(gpio_bank_pkg::P1_MODE_A_ADDR, 8'hff);
        rd(gpio_bank_pkg::P3_MODE_B_ADDR, 8'h00);
        rd(gpio_bank_pkg::ANALOG_DIS_ADDR, 8'h00);
        rd(gpio_bank_pkg::STATUS_ADDR, 8'h12);
        rd(4'hf, 8'h00);
        rd(gpio_bank_pkg::P0_PINS_ADDR, 8'hff);
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        do_reset();
        chk_reset();
        for (int m = 0; m < 4; m++) begin
            code = 2'(m);
            for (int p = 0; p < 3; p++) begin
                wr(4'(4 * p + 1), {8{code[1]}});
                wr(4'(4 * p + 2), {8{code[0]}});
                wr(4'(4 * p), LAT[8 * p +: 8]);
            end
            repeat (2) @(negedge mclk_i);
            for (int i = 0; i < 18; i++) begin
                c = code;
                if (i == gpio_bank_pkg::RESET_PIN_IDX) begin
                    c = gpio_bank_pkg::INPUT_ONLY;
                end else if ((i == gpio_bank_pkg::SCL_PIN_IDX ||
                              i == gpio_bank_pkg::SDA_PIN_IDX) && !code[1]) begin
                    c = gpio_bank_pkg::OPEN_DRAIN;
                end
                cmp(18'({oes[i], outs[i] & oes[i], pus[i]}), 18'(pin_exp(c, LAT[i])));
            end
            rd(gpio_bank_pkg::P1_MODE_A_ADDR, {8{code[1]}} | gpio_bank_pkg::P1_FIXED_BIT);
            rd(gpio_bank_pkg::P1_MODE_B_ADDR, {8{code[0]}} & ~gpio_bank_pkg::P1_FIXED_BIT);
        end
        // Analog pins go input-only before their inputs are cut off
        wr(gpio_bank_pkg::P0_MODE_A_ADDR, 8'h3e);
        wr(gpio_bank_pkg::P0_MODE_B_ADDR, 8'h00);
        wr(gpio_bank_pkg::P0_LATCH_ADDR, 8'hff);
        wr(gpio_bank_pkg::ANALOG_DIS_ADDR, 8'hff);
        ext_low <= 18'h00081;
        rd(gpio_bank_pkg::ANALOG_DIS_ADDR, 8'h3e);
        repeat (4) @(posedge mclk_i);
        rd(gpio_bank_pkg::P0_PINS_ADDR, 8'h40);
        cmp(18'({oes[7:0], pus[7:0]}), 18'h000c1);
        ext_low <= 18'h00000;
        do_reset();
        chk_reset();
        // Port 3 pushes high so that pins taken by the clock show as released
        wr(gpio_bank_pkg::P3_MODE_A_ADDR, 8'h00);
        wr(gpio_bank_pkg::P3_MODE_B_ADDR, 8'h03);
        for (int k = 0; k < 8; k++) begin
            wr(gpio_bank_pkg::USER_CFG_ADDR, 8'(k));
            rd(gpio_bank_pkg::STATUS_ADDR, 8'(18 - (k[1] ? 1 + k[0] : 0) - k[2]));
            cmp(18'(oes[17:16]), 18'(k[1] ? {1'b0, ~k[0]} : 2'h3));
        end
        ext_low <= 18'h02000;
        repeat (5) @(negedge mclk_i);
        cmp(18'(ext_reset_o), 18'h00001);
        wr(gpio_bank_pkg::USER_CFG_ADDR, 8'h00);
        repeat (5) @(negedge mclk_i);
        cmp(18'(ext_reset_o), 18'h00000);
        rd(gpio_bank_pkg::P1_PINS_ADDR, 8'hdf);
        // A write while the clock enable is low must leave the latch alone
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(gpio_bank_pkg::P0_LATCH_ADDR, 8'h00);
        ce_i <= 1'b1;
        rd(gpio_bank_pkg::P0_LATCH_ADDR, 8'hff);
        print_verdict();
    end
endmodule

`default_nettype wire
